// file: src/slwc_pkg.sv
/*
 * shared constants for the segment display waveform controller: register
 * indexes, field positions, reset values, level codes and mode codes.
 * assumes a 32-bit apb slave where byte address = 4 * register index.
 */
package slwc_pkg;

    // register indexes, byte address is four times the index
    localparam logic [11:0] IDX_INDEX   = 12'hFB1;
    localparam logic [11:0] IDX_PORTAL  = 12'hFB2;
    localparam logic [11:0] IDX_CLOCK   = 12'hFB3;
    localparam logic [11:0] IDX_CTL0    = 12'hFB4;
    localparam logic [11:0] IDX_CTL1    = 12'hFB5;
    localparam logic [11:0] IDX_CTL2    = 12'hFB6;
    localparam logic [11:0] IDX_CTL3    = 12'hFB7;
    localparam logic [11:0] IDX_POWER   = 12'hFB8;

    localparam logic [7:0]  RST_REG     = 8'h00;
    localparam logic [4:0]  RST_INDEX   = 5'h00;

    // field positions
    localparam int CLK_PRE_LSB  = 4;
    localparam int CLK_FDIV_LSB = 0;
    localparam int CTL0_BDIV_LSB = 3;
    localparam int CTL0_BLNK_LSB = 1;
    localparam int CTL1_PUMP_BIT = 7;
    localparam int CTL1_CTR_LSB  = 0;
    localparam int CTL2_MODE_LSB = 0;
    localparam int CTL2_BANK_LSB = 4;
    localparam int CTL2_SRC_BIT  = 6;
    localparam int CTL3_WGEN_BIT = 0;
    localparam int PWR_EN_BIT    = 0;

    // display memory geometry
    localparam int          MEM_BYTES   = 12;
    localparam int          NUM_SEG     = 24;
    localparam int          NUM_COM     = 4;
    localparam logic [3:0]  LOW_LAST    = 4'hB;
    localparam logic [4:0]  BANK_A_BASE = 5'h00;
    localparam logic [4:0]  BANK_B_BASE = 5'h10;

    // phases per frame before dead cycles, and blink divider constants
    localparam logic [3:0]  PHASES_FULL  = 4'h8;
    localparam logic [3:0]  PHASES_THIRD = 4'h6;
    localparam logic [7:0]  BLINK_MULT   = 8'h04;
    localparam logic [4:0]  BDIV_BASE    = 5'h02;

    // drive level codes: gnd, 1/3 (or 1/2 in half bias), 2/3, full
    localparam logic [1:0]  LVL_GND  = 2'h0;
    localparam logic [1:0]  LVL_LOW  = 2'h1;
    localparam logic [1:0]  LVL_HIGH = 2'h2;
    localparam logic [1:0]  LVL_VLCD = 2'h3;

    // blink pattern and memory bank modes
    localparam logic [1:0]  BLINK_OFF  = 2'h0;
    localparam logic [1:0]  BLINK_ONE  = 2'h1;
    localparam logic [1:0]  BLINK_COL  = 2'h2;
    localparam logic [1:0]  BANK_A     = 2'h0;
    localparam logic [1:0]  BANK_B     = 2'h1;
    localparam logic [1:0]  BANK_ALT   = 2'h2;
    localparam logic [1:0]  BANK_BLANK = 2'h3;

    typedef enum logic [2:0] {
        DUTY_STATIC,
        DUTY_HALF,
        DUTY_THIRD,
        DUTY_QUARTER,
        DUTY_RSVD
    } slwc_duty_e;

endpackage

// file: src/slwc_ctrl.sv
/*
 * segment display waveform controller: apb register file, display memory
 * portal, frame timing, common/segment level generation, frame/blink event.
 * assumes the apb master and the analog level drivers share i_clk_sys.
 */
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
module slwc_ctrl (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [13:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    output logic      [7:0]  o_com_level,
    output logic      [47:0] o_seg_level,
    output logic             o_bias_half,
    output logic             o_pump_on,
    output logic      [2:0]  o_pump_level,
    output logic             o_wave_active,
    output logic             o_display_event
);

    logic [4:0]  index_q;
    logic [7:0]  clock_q, ctl0_q, ctl1_q, ctl2_q, ctl3_q, power_q;
    logic [7:0]  a_clock_q, a_ctl0_q, a_ctl1_q, a_ctl2_q, a_ctl3_q;
    logic [7:0]  mem_q [0:slwc_pkg::NUM_SEG-1];
    logic [31:0] prdata_q;
    logic        run_q, frame_odd_q, blink_off_q, bank_sel_q, event_q;
    logic [4:0]  pre_cnt_q, fdiv_cnt_q;
    logic [3:0]  phase_q;
    logic [7:0]  blink_cnt_q;
    logic [7:0]  com_q;
    logic [47:0] seg_q;

    logic        setup, access, hit, portal_ok, is_portal;
    logic [11:0] widx;
    logic [4:0]  flat, next_index;
    logic [7:0]  wbyte, rd_byte;
    logic        pre_tick, phase_tick, frame_end, blink_tick;
    logic [4:0]  pre_top, fdiv_top;
    logic [3:0]  mode, act_phases, last_phase, dead;
    logic [1:0]  blink_mode, bank_mode;
    slwc_pkg::slwc_duty_e duty;
    logic        third_bias, type_b, out_en, dead_ph, pol;
    logic [1:0]  com_sel;

    // apb decode: answer in the first access cycle, no wait states
    assign setup     = i_psel & ~i_penable;
    assign access    = i_psel & i_penable;
    assign widx      = i_paddr[13:2];
    assign wbyte     = i_pwdata[7:0];
    assign is_portal = (i_paddr[1:0] == 2'h0) && (widx == slwc_pkg::IDX_PORTAL);
    assign hit       = (i_paddr[1:0] == 2'h0) && (widx >= slwc_pkg::IDX_INDEX)
                       && (widx <= slwc_pkg::IDX_POWER);
    assign o_pready  = access;
    assign o_pslverr = access & ~hit;
    assign o_prdata  = prdata_q;

    // portal address: bank select in bit 4, byte in the low nibble
    assign portal_ok = (index_q[3:0] <= slwc_pkg::LOW_LAST);
    assign flat = index_q[4] ? 5'(index_q[3:0] + 4'(slwc_pkg::MEM_BYTES))
                             : {1'b0, index_q[3:0]};
    assign rd_byte = portal_ok ? mem_q[flat] : 8'h00;

    // wrap at the end of each bank so streaming stays inside it
    always_comb begin
        if (index_q[3:0] >= slwc_pkg::LOW_LAST) begin
            next_index = index_q[4] ? slwc_pkg::BANK_B_BASE
                                    : slwc_pkg::BANK_A_BASE;
        end else begin
            next_index = 5'(index_q + 5'h01);
        end
    end

    // read data captured in the setup cycle, held through the access
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup && !i_pwrite) begin
            // unaligned words fall to the default arm and read as zero
            unique case (hit ? widx : 12'h000)
                slwc_pkg::IDX_INDEX:  prdata_q <= {27'h0, index_q};
                slwc_pkg::IDX_PORTAL: prdata_q <= {24'h0, rd_byte};
                slwc_pkg::IDX_CLOCK:  prdata_q <= {24'h0, clock_q};
                slwc_pkg::IDX_CTL0:   prdata_q <= {24'h0, ctl0_q};
                slwc_pkg::IDX_CTL1:   prdata_q <= {24'h0, ctl1_q};
                slwc_pkg::IDX_CTL2:   prdata_q <= {24'h0, ctl2_q};
                slwc_pkg::IDX_CTL3:   prdata_q <= {24'h0, ctl3_q};
                slwc_pkg::IDX_POWER:  prdata_q <= {24'h0, power_q};
                default:              prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // software copies of the control registers, readable at once
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            clock_q <= slwc_pkg::RST_REG;
            ctl0_q  <= slwc_pkg::RST_REG;
            ctl1_q  <= slwc_pkg::RST_REG;
            ctl2_q  <= slwc_pkg::RST_REG;
            ctl3_q  <= slwc_pkg::RST_REG;
            power_q <= slwc_pkg::RST_REG;
        end else if (access && i_pwrite && hit) begin
            if (widx == slwc_pkg::IDX_CLOCK) clock_q <= wbyte;
            if (widx == slwc_pkg::IDX_CTL0)  ctl0_q  <= wbyte;
            if (widx == slwc_pkg::IDX_CTL1)  ctl1_q  <= wbyte;
            if (widx == slwc_pkg::IDX_CTL2)  ctl2_q  <= wbyte;
            if (widx == slwc_pkg::IDX_CTL3)  ctl3_q  <= wbyte;
            if (widx == slwc_pkg::IDX_POWER) power_q <= wbyte;
        end
    end

    // index register: written directly, bumped by any portal access
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            index_q <= slwc_pkg::RST_INDEX;
        end else if (access && hit && widx == slwc_pkg::IDX_INDEX && i_pwrite) begin
            index_q <= wbyte[4:0];
        end else if (access && is_portal) begin
            index_q <= next_index;
        end
    end

    // display memory; reserved indexes swallow writes
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < slwc_pkg::NUM_SEG; i++) begin
                mem_q[i] <= slwc_pkg::RST_REG;
            end
        end else if (access && i_pwrite && is_portal && portal_ok) begin
            mem_q[flat] <= wbyte;
        end
    end

    // active copies change on a frame boundary, or at once while stopped, to keep dc balance
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            a_clock_q <= slwc_pkg::RST_REG;
            a_ctl0_q  <= slwc_pkg::RST_REG;
            a_ctl1_q  <= slwc_pkg::RST_REG;
            a_ctl2_q  <= slwc_pkg::RST_REG;
            a_ctl3_q  <= slwc_pkg::RST_REG;
        end else if (frame_end || !run_q) begin
            a_clock_q <= clock_q;
            a_ctl0_q  <= ctl0_q;
            a_ctl1_q  <= ctl1_q;
            a_ctl2_q  <= ctl2_q;
            a_ctl3_q  <= ctl3_q;
        end
    end

    // run flag ignores stop mode; a cleared enable finishes the frame
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            run_q <= 1'b0;
        end else if (power_q[slwc_pkg::PWR_EN_BIT]) begin
            run_q <= 1'b1;
        end else if (frame_end) begin
            run_q <= 1'b0;
        end
    end

    // mode decode
    assign mode       = a_ctl2_q[slwc_pkg::CTL2_MODE_LSB +: 4];
    assign bank_mode  = a_ctl2_q[slwc_pkg::CTL2_BANK_LSB +: 2];
    assign blink_mode = a_ctl0_q[slwc_pkg::CTL0_BLNK_LSB +: 2];
    always_comb begin
        third_bias = 1'b0;
        type_b     = 1'b0;
        if (mode == 4'h0) begin
            duty = slwc_pkg::DUTY_STATIC;
        end else if (mode <= 4'h4) begin
            duty = slwc_pkg::DUTY_HALF;
        end else if (mode <= 4'h8) begin
            duty = slwc_pkg::DUTY_THIRD;
        end else if (mode <= 4'hC) begin
            duty = slwc_pkg::DUTY_QUARTER;
        end else begin
            duty = slwc_pkg::DUTY_RSVD;
        end
        if (duty != slwc_pkg::DUTY_STATIC && duty != slwc_pkg::DUTY_RSVD) begin
            // bit 1 of the code minus one marks the second pair of a group
            third_bias = |(4'(mode - 4'h1) & 4'h2);
            type_b     = ~mode[0];
        end
    end

    // pump sets level; without it the same field inserts dead cycles
    assign dead         = a_ctl1_q[slwc_pkg::CTL1_PUMP_BIT] ? 4'h0
                          : {1'b0, a_ctl1_q[slwc_pkg::CTL1_CTR_LSB +: 3]};
    assign o_pump_on    = run_q & a_ctl1_q[slwc_pkg::CTL1_PUMP_BIT];
    assign o_pump_level = o_pump_on ? a_ctl1_q[slwc_pkg::CTL1_CTR_LSB +: 3]
                                    : 3'h0;
    assign act_phases   = (duty == slwc_pkg::DUTY_THIRD) ? slwc_pkg::PHASES_THIRD
                                                         : slwc_pkg::PHASES_FULL;
    assign last_phase   = 4'(act_phases + dead - 4'h1);
    assign out_en       = run_q && a_ctl3_q[slwc_pkg::CTL3_WGEN_BIT]
                          && duty != slwc_pkg::DUTY_RSVD;
    assign o_wave_active = out_en;
    assign o_bias_half   = ~third_bias;

    // prescaler then frame divider, each one-cycle enables
    always_comb begin
        pre_top = 5'((6'h01 << a_clock_q[slwc_pkg::CLK_PRE_LSB +: 3]) - 6'h01);
        if (a_clock_q[slwc_pkg::CLK_PRE_LSB +: 3] > 3'h5) begin
            pre_top = 5'h1F;
        end
        if (a_clock_q[slwc_pkg::CLK_FDIV_LSB +: 4] <= 4'h6) begin
            fdiv_top = 5'(a_clock_q[slwc_pkg::CLK_FDIV_LSB +: 4] + 4'h7);
        end else begin
            fdiv_top = 5'({a_clock_q[slwc_pkg::CLK_FDIV_LSB +: 4], 1'b0} + 5'h01);
        end
    end
    assign pre_tick   = run_q && pre_cnt_q == pre_top;
    assign phase_tick = pre_tick && fdiv_cnt_q == fdiv_top;
    assign frame_end  = phase_tick && phase_q >= last_phase;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            pre_cnt_q  <= 5'h00;
            fdiv_cnt_q <= 5'h00;
            phase_q    <= 4'h0;
        end else if (!run_q) begin
            pre_cnt_q  <= 5'h00;
            fdiv_cnt_q <= 5'h00;
            phase_q    <= 4'h0;
        end else begin
            pre_cnt_q  <= pre_tick ? 5'h00 : 5'(pre_cnt_q + 5'h01);
            if (pre_tick) begin
                fdiv_cnt_q <= phase_tick ? 5'h00 : 5'(fdiv_cnt_q + 5'h01);
            end
            if (phase_tick) begin
                phase_q <= frame_end ? 4'h0 : 4'(phase_q + 4'h1);
            end
        end
    end

    // frame parity, blink divider, blink and bank state, event pulse
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            frame_odd_q <= 1'b0;
            blink_cnt_q <= 8'h00;
            blink_off_q <= 1'b0;
            bank_sel_q  <= 1'b0;
            event_q     <= 1'b0;
        end else begin
            event_q <= 1'b0;
            if (frame_end) begin
                frame_odd_q <= ~frame_odd_q;
                blink_cnt_q <= blink_tick ? 8'h00 : 8'(blink_cnt_q + 8'h01);
                if (!a_ctl2_q[slwc_pkg::CTL2_SRC_BIT]) begin
                    event_q <= 1'b1;
                end
            end
            if (blink_tick) begin
                blink_off_q <= ~blink_off_q;
                if (bank_mode == slwc_pkg::BANK_ALT) begin
                    bank_sel_q <= ~bank_sel_q;
                end
                if (a_ctl2_q[slwc_pkg::CTL2_SRC_BIT]) begin
                    if (bank_mode == slwc_pkg::BANK_ALT) begin
                        event_q <= ~bank_sel_q;
                    end else if (blink_mode != slwc_pkg::BLINK_OFF) begin
                        event_q <= ~blink_off_q;
                    end
                end
            end
        end
    end
    assign blink_tick = frame_end && blink_cnt_q == 8'(slwc_pkg::BLINK_MULT
                        * 8'(a_ctl0_q[slwc_pkg::CTL0_BDIV_LSB +: 5] + slwc_pkg::BDIV_BASE)
                        - 8'h01);
    assign o_display_event = event_q;

    // phase to common slot and polarity
    assign dead_ph = phase_q >= act_phases;
    always_comb begin
        unique case (duty)
            slwc_pkg::DUTY_STATIC:  com_sel = 2'h0;
            slwc_pkg::DUTY_HALF:    com_sel = {1'b0, phase_q[2]};
            slwc_pkg::DUTY_THIRD:   com_sel = phase_q[2:1];
            slwc_pkg::DUTY_QUARTER: com_sel = phase_q[2:1];
            default:                com_sel = 2'h0;
        endcase
        pol = (type_b && duty != slwc_pkg::DUTY_STATIC) ? ~frame_odd_q : ~phase_q[0];
    end

    // common levels; unused commons rest at ground
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            com_q <= 8'h00;
        end else begin
            for (int c = 0; c < slwc_pkg::NUM_COM; c++) begin
                if (!out_en || dead_ph) begin
                    com_q[2*c +: 2] <= slwc_pkg::LVL_GND;
                end else if (c == int'(com_sel)) begin
                    com_q[2*c +: 2] <= pol ? slwc_pkg::LVL_VLCD
                                           : slwc_pkg::LVL_GND;
                end else if (duty == slwc_pkg::DUTY_STATIC
                             || (duty == slwc_pkg::DUTY_HALF && c > 1)
                             || (duty == slwc_pkg::DUTY_THIRD && c > 2)) begin
                    com_q[2*c +: 2] <= slwc_pkg::LVL_GND;
                end else if (third_bias) begin
                    com_q[2*c +: 2] <= pol ? slwc_pkg::LVL_LOW : slwc_pkg::LVL_HIGH;
                end else begin
                    com_q[2*c +: 2] <= slwc_pkg::LVL_LOW;
                end
            end
        end
    end
    assign o_com_level = com_q;

    // segment levels from the selected bank nibble, blink and blank masks
    for (genvar s = 0; s < slwc_pkg::NUM_SEG; s++) begin : g_seg
        logic [7:0] byte_v;
        logic [3:0] nib;
        logic       on, hide;
        logic [1:0] lvl;
        assign byte_v = (bank_mode == slwc_pkg::BANK_B
                        || (bank_mode == slwc_pkg::BANK_ALT && bank_sel_q))
                        ? mem_q[s/2 + slwc_pkg::MEM_BYTES] : mem_q[s/2];
        assign nib    = (s % 2 == 1) ? byte_v[7:4] : byte_v[3:0];
        always_comb begin
            hide = 1'b0;
            if (bank_mode == slwc_pkg::BANK_BLANK) begin
                hide = 1'b1;
            end else if (bank_mode != slwc_pkg::BANK_ALT && blink_off_q) begin
                unique case (blink_mode)
                    slwc_pkg::BLINK_OFF: hide = 1'b0;
                    slwc_pkg::BLINK_ONE: hide = (s == 0) && (com_sel == 2'h0);
                    slwc_pkg::BLINK_COL: hide = (s == 0);
                    default:             hide = 1'b1;
                endcase
            end
            on = nib[com_sel] & ~hide;
            if (!out_en || dead_ph) begin
                lvl = slwc_pkg::LVL_GND;
            end else if (on) begin
                lvl = pol ? slwc_pkg::LVL_GND : slwc_pkg::LVL_VLCD;
            end else if (duty == slwc_pkg::DUTY_STATIC) begin
                lvl = pol ? slwc_pkg::LVL_VLCD : slwc_pkg::LVL_GND;
            end else if (third_bias) begin
                lvl = pol ? slwc_pkg::LVL_HIGH : slwc_pkg::LVL_LOW;
            end else begin
                lvl = slwc_pkg::LVL_LOW;
            end
        end
        always_ff @(posedge i_clk_sys or posedge i_rst) begin
            if (i_rst) begin
                seg_q[2*s +: 2] <= slwc_pkg::LVL_GND;
            end else begin
                seg_q[2*s +: 2] <= lvl;
            end
        end
    end
    assign o_seg_level = seg_q;

endmodule

// file: test/slwc_glass_model.sv
/* passive glass model: marks segment 0 lit when it sees full drive on it.
   assumes level codes 0..3 and common 0 carrying that segment's bit. */
`timescale 1ns/10ps
module slwc_glass_model (
    input  wire logic        i_clk_sys,
    input  wire logic [7:0]  i_com_level,
    input  wire logic [47:0] i_seg_level,
    input  wire logic        i_clear,
    output logic             o_seg0_lit
);
    // only full swing counts, so bias steps of an unlit segment never light it
    always_ff @(posedge i_clk_sys) begin
        if (i_clear) begin
            o_seg0_lit <= 1'b0;
        end else if ({i_com_level[1:0], i_seg_level[1:0]} inside {4'hC, 4'h3}) begin
            o_seg0_lit <= 1'b1;
        end
    end
endmodule

// file: test/slwc_ctrl_asserts.sv
/* checker for slwc_ctrl bus answers and drive levels.
   assumes it is bound to the design top; one clock domain. */
`timescale 1ns/10ps
module slwc_ctrl_asserts (
    input wire logic        i_clk_sys,
    input wire logic        i_rst,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [13:0] i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic [7:0]  o_com_level,
    input wire logic [47:0] o_seg_level,
    input wire logic        o_pump_on,
    input wire logic [2:0]  o_pump_level,
    input wire logic        o_wave_active,
    input wire logic        o_display_event
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    // access phase, and a word outside the register block
    wire acc = i_psel && i_penable;
    wire off = i_paddr[13:2] < 12'hFB1 || i_paddr[13:2] > 12'hFB8;
    chk_ready_now: assert property (acc |-> o_pready)
        else $error("no ready in access");
    chk_err_unmapped: assert property (acc && off |-> o_pslverr)
        else $error("no error on unmapped word");
    chk_err_reads_zero: assert property (acc && !i_pwrite && o_pslverr |-> o_prdata == 32'h0)
        else $error("refused read not zero");
    chk_upper_zero: assert property (o_prdata[31:8] == 24'h0)
        else $error("read data above byte");
    chk_pump_idle: assert property (!o_pump_on |-> o_pump_level == 3'h0)
        else $error("pump level while off");
    // one cycle of lag allowed for the registered levels
    chk_idle_gnd: assert property (!o_wave_active [*2] |-> o_com_level == 8'h0 && o_seg_level == 48'h0)
        else $error("levels while idle");
    chk_event_pulse: assert property (o_display_event |=> !o_display_event)
        else $error("event longer than a cycle");
    // a phase is at least eight clocks at the fastest divider
    chk_level_hold: assert property ($changed(o_com_level) |=> $stable(o_com_level) [*6])
        else $error("common level phase too short");
endmodule
bind slwc_ctrl slwc_ctrl_asserts u_chk (.i_clk_sys, .i_rst, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .o_prdata, .o_pready, .o_pslverr, .o_com_level, .o_seg_level, .o_pump_on,
    .o_pump_level, .o_wave_active, .o_display_event);

// file: test/slwc_ctrl_tb.sv
/* self-checking bench for slwc_ctrl: registers, memory portal, drive codes,
   pump and power-down. assumes the glass model and bound checker. */
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("BAD t=%0t got %0h exp %0h", $time, a, b); end end
module slwc_ctrl_tb;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        pready, pslverr, bias, pon, act, ev, lit, err, valid, clr = 1'b1;
    logic [13:0] paddr = 14'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [7:0]  com, rd, seen, mask;
    logic [47:0] seg;
    logic [2:0]  plvl;
    int          error_cnt = 0, total_checks = 0, n, evs, run, maxrun;
    // rows: index, write, readback, error
    logic [28:0] tbl [8] = '{{12'hFB3, 8'hA5, 8'hA5, 1'b0}, {12'hFB4, 8'hF6, 8'hF6, 1'b0},
        {12'hFB5, 8'h87, 8'h87, 1'b0}, {12'hFB6, 8'h45, 8'h45, 1'b0},
        {12'hFB7, 8'h01, 8'h01, 1'b0}, {12'hFB1, 8'hFF, 8'h1F, 1'b0},
        {12'hFB0, 8'h55, 8'h00, 1'b1}, {12'hFB9, 8'h55, 8'h00, 1'b1}};
    slwc_ctrl dut (.i_clk_sys(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_com_level(com), .o_seg_level(seg),
        .o_bias_half(bias), .o_pump_on(pon), .o_pump_level(plvl), .o_wave_active(act),
        .o_display_event(ev));
    slwc_glass_model glass (.i_clk_sys(clk), .i_com_level(com), .i_seg_level(seg),
        .i_clear(clr), .o_seg0_lit(lit));
    // 25 mhz
    always #20 clk = ~clk;
    // one transfer; the idle edge first keeps strobes from double assignment
    task automatic apb(input logic [11:0] idx, input logic wr, input logic [7:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // the run needs about 7100 cycles, so this only trips on a hang
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        close_out();
    end
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int i = 12'hFB1; i <= 12'hFB8; i++) begin
            apb(i[11:0], 1'b0, 8'h0);
            `CHK(rd, 8'h00)
        end
        foreach (tbl[i]) begin
            apb(tbl[i][28:17], 1'b1, tbl[i][16:9]);
            apb(tbl[i][28:17], 1'b0, 8'h0);
            `CHK({rd, err}, tbl[i][8:0])
        end
        // three writes from 0ah wrap the pointer through 0bh to 00h
        apb(12'hFB1, 1'b1, 8'h0A);
        for (int i = 0; i < 3; i++) apb(12'hFB2, 1'b1, 8'hD1 + i[7:0]);
        apb(12'hFB1, 1'b0, 8'h0);
        `CHK(rd, 8'h01)
        apb(12'hFB1, 1'b1, 8'h0A);
        for (int i = 0; i < 3; i++) begin
            apb(12'hFB2, 1'b0, 8'h0);
            `CHK(rd, 8'hD1 + i[7:0])
        end
        apb(12'hFB1, 1'b1, 8'h1B);
        apb(12'hFB2, 1'b1, 8'hEE);
        apb(12'hFB1, 1'b0, 8'h0);
        `CHK(rd, 8'h10)
        // fastest clock, no blink, no dead cycles, then waveform and power on
        for (int i = 3; i <= 8; i++) if (i != 6) apb(12'hFB0 + i[11:0], 1'b1, 8'(i > 6));
        // every drive code, segment 0 lit on common 0 by byte 00h = d3h
        for (int code = 0; code < 14; code++) begin
            valid = code < 13;
            n = (code == 0) ? 1 : (code + 7) / 4;
            mask = valid ? 8'hFF >> (8 - 2 * n) : 8'h00;
            clr <= 1'b1;
            apb(12'hFB6, 1'b1, code[7:0]);
            repeat (200) @(posedge clk);
            clr <= 1'b0;
            seen = 8'h0;
            evs = 0;
            run = 0;
            maxrun = 0;
            // two and a half 64-cycle frames, so one whole full-swing slot of common 0 lies inside
            repeat (160) begin
                @(posedge clk);
                seen = seen | com;
                evs = evs + int'(ev);
                run = (com[1:0] == 2'h3) ? run + 1 : 0;
                maxrun = (run > maxrun) ? run : maxrun;
            end
            `CHK(seen & ~mask, 8'h00)
            `CHK(lit, valid)
            if (valid) `CHK((seen & mask) != 8'h0, 1'b1)
            if (valid) `CHK(evs > 0, 1'b1)
            if (code > 0 && valid) `CHK(bias, ((code - 1) % 4) < 2)
            // type a flips the selected common each phase, type b holds its slot
            if (valid) `CHK(maxrun, (code % 2 || !code) ? 8 : (n == 2 ? 32 : 16))
        end
        // bank alternation, blink source: one a-to-b switch per 16 frames of 64
        apb(12'hFB6, 1'b1, 8'h6B);
        repeat (200) @(posedge clk);
        evs = 0;
        repeat (1024) begin
            @(posedge clk);
            evs = evs + int'(ev);
        end
        `CHK(evs, 1)
        // blanking must hide segment 0 although its memory bit stays set
        clr <= 1'b1;
        apb(12'hFB6, 1'b1, 8'h3B);
        repeat (200) @(posedge clk);
        clr <= 1'b0;
        repeat (160) @(posedge clk);
        `CHK(lit, 1'b0)
        apb(12'hFB6, 1'b1, 8'h0B);
        apb(12'hFB5, 1'b1, 8'h85);
        repeat (200) @(posedge clk);
        `CHK({pon, plvl}, 4'hD)
        apb(12'hFB8, 1'b1, 8'h00);
        n = 0;
        while (act === 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        // the common levels are registered, so they reach ground one edge later
        @(posedge clk);
        `CHK({act, com}, 9'h000)
        // mid-run reset brings the registers back to zero
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        apb(12'hFB5, 1'b0, 8'h0);
        `CHK(rd, 8'h00)
        apb(12'hFB6, 1'b0, 8'h0);
        `CHK(rd, 8'h00)
        close_out();
    end
endmodule
